// ---- quad_rail_sequencer_fsm.sv ----
// four-rail up/down power sequencer core
// assumes filtered comparator levels; rst_n is the supply lockout
`timescale 1ns/1ps
`default_nettype none
`include "seq_cfg.svh"
module quad_rail_sequencer_fsm
	import seq_pkg::*;
#(
	parameter int RAILS = `SEQ_RAILS
)
(
	input  wire logic                 clk_sys,
	input  wire logic                 rst_n,
	input  wire logic                 reduced_variant,
	input  wire logic [RAILS-1:0]     rail_good_in,
	input  wire request_s             request_in,
	input  wire count_t               stage_delay [RAILS],
	input  wire count_t               blanking_window,
	input  wire count_t               fault_hold,
	output logic      [RAILS-1:0]     rail_enable_out,
	output logic                      sequence_complete,
	output logic                      all_rails_good,
	output logic                      fault_n_out,
	output logic                      fault_n_oe,
	output seq_state_e                state_out
);
	logic [2:0] lvl;
	logic [2:0] rise;
	logic [2:0] fall;
	seq_state_e state;
	count_t     timer;
	logic [1:0] stage;
	logic       up_in;
	logic       up_rise;
	logic       down_fall;
	logic       up_low;
	logic       ext_fault;
	logic       rail_lost;
	logic       bad_edge;
	logic       timer_done;
	logic [3:0] oe_hist;

	sync_edge #(.WIDTH(3)) u_sync
	(
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.din     ({request_in.fault_n, request_in.down, request_in.up}),
		.level   (lvl),
		.rise    (rise),
		.fall    (fall)
	);

	// reduced variant uses up pin as combined direction
	assign up_in      = lvl[0];
	assign up_rise    = rise[0];
	assign down_fall  = reduced_variant ? fall[0] : fall[1];
	assign up_low     = !up_in && !rise[0];
	// own pull still in the synchroniser is not a peer fault
	assign ext_fault  = !reduced_variant && !lvl[2] && fault_n_oe == 1'b0 && !(|oe_hist)
		&& state != ST_CLEAR_FAULT && state != ST_SET_FAULT;
	assign timer_done = (timer == `SEQ_CNT_ZERO);
	assign rail_lost  = |(rail_enable_out & ~rail_good_in & ~(state == ST_ENABLE ? (4'h1 << stage) : 4'h0));
	assign bad_edge   = (state == ST_WAIT_START && down_fall)
		|| ((state == ST_DELAY || state == ST_ENABLE) && down_fall)
		|| ((state == ST_DISABLE || state == ST_DOWN_DELAY || state == ST_DONE) && up_rise
			&& !reduced_variant)
		|| ((state == ST_DISABLE || state == ST_DOWN_DELAY) && up_rise);
	assign state_out  = state;

	// recent own pull on the fault line
	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
			oe_hist <= 4'h0;
		else
			oe_hist <= {oe_hist[2:0], fault_n_oe};
	end

	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
			all_rails_good <= 1'b0;
		else
			all_rails_good <= &rail_good_in;
	end

	// state, timer and stage
	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			state <= ST_SET_FAULT;
			timer <= fault_hold;
			stage <= 2'd0;
		end
		else if (state != ST_SET_FAULT && state != ST_CLEAR_FAULT
			&& (ext_fault || bad_edge || (rail_lost && state != ST_WAIT_START)))
		begin
			state <= ST_SET_FAULT;
			timer <= fault_hold;
		end
		else
		begin
			if (!timer_done)
				timer <= timer - `SEQ_CNT_ONE;
			case (state)
				ST_SET_FAULT:
				begin
					if (timer_done || timer == `SEQ_CNT_ONE)
						state <= ST_CLEAR_FAULT;
				end
				ST_CLEAR_FAULT:
				begin
					if (up_low)
						state <= ST_WAIT_START;
				end
				ST_WAIT_START:
				begin
					if (up_rise)
					begin
						stage <= 2'd0;
						if (reduced_variant)
						begin
							state <= ST_ENABLE;
							timer <= blanking_window;
						end
						else
						begin
							state <= ST_DELAY;
							timer <= stage_delay[0];
						end
					end
				end
				ST_DELAY:
				begin
					if (timer_done)
					begin
						state <= ST_ENABLE;
						timer <= blanking_window;
					end
				end
				ST_ENABLE:
				begin
					if (rail_good_in[stage])
					begin
						if (stage == 2'd3)
							state <= ST_DONE;
						else
						begin
							stage <= stage + 2'd1;
							state <= ST_DELAY;
							timer <= stage_delay[stage + 2'd1];
						end
					end
					else if (timer_done)
					begin
						state <= ST_SET_FAULT;
						timer <= fault_hold;
					end
				end
				ST_DONE:
				begin
					if (down_fall)
					begin
						state <= ST_DOWN_DELAY;
						stage <= 2'd3;
						timer <= stage_delay[3];
					end
				end
				ST_DOWN_DELAY:
				begin
					if (timer_done)
					begin
						if (stage == 2'd0)
							state <= ST_WAIT_START;
						else
						begin
							stage <= stage - 2'd1;
							timer <= (stage == 2'd1 && reduced_variant) ? `SEQ_CNT_ZERO : stage_delay[stage - 2'd1];
						end
					end
				end
				default:
					state <= ST_SET_FAULT;
			endcase
		end
	end

	// enables follow state
	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
			rail_enable_out <= `SEQ_RAILS_OFF;
		else if (state == ST_SET_FAULT || state == ST_CLEAR_FAULT || state == ST_WAIT_START)
			rail_enable_out <= `SEQ_RAILS_OFF;
		else if (state == ST_ENABLE)
			rail_enable_out <= rail_enable_out | (4'h1 << stage);
		else if (state == ST_DOWN_DELAY)
			rail_enable_out <= rail_enable_out & ~(4'hf << stage);
	end

	// complete and fault line
	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			sequence_complete <= 1'b0;
			fault_n_oe        <= 1'b0;
		end
		else
		begin
			// powered; held through down; fault clears
			sequence_complete <= (state == ST_DONE) || (state == ST_DOWN_DELAY);
			// line pulled in fault except in the reduced variant, released after
			fault_n_oe <= !reduced_variant && (state == ST_SET_FAULT || state == ST_CLEAR_FAULT);
		end
	end
	assign fault_n_out = 1'b0;
endmodule // quad_rail_sequencer_fsm
`default_nettype wire

// ---- seq_cfg.svh ----
// timing defaults and fixed field values for the rail sequencer
// assumes inclusion by seq_pkg and the sequencer modules
`ifndef SEQ_CFG_SVH
`define SEQ_CFG_SVH
`define SEQ_RAILS      4
`define SEQ_CNT_W      24
`define SEQ_CNT_ZERO   24'h000000
`define SEQ_CNT_ONE    24'h000001
`define SEQ_RAILS_OFF  4'h0
`define SEQ_RAILS_ALL  4'hf
// stage delays and blanking in cycles at 25 MHz
`define SEQ_STAGE_DEF  24'h0009c4
`define SEQ_BLANK_DEF  24'h0009c4
// fault hold: 44 us at 40 ns per cycle
`define SEQ_HOLD_US    44
`define SEQ_CLK_NS     40
`define SEQ_HOLD_DEF   24'h00044c
`endif

// ---- seq_pkg.sv ----
// types shared by the rail sequencer files
// assumes seq_cfg.svh in the same folder
`include "seq_cfg.svh"
package seq_pkg;
	typedef logic [`SEQ_CNT_W-1:0] count_t;
	typedef struct packed
	{
		logic up;
		logic down;
		logic fault_n;
	} request_s;
	typedef enum logic [3:0]
	{
		ST_SET_FAULT,
		ST_CLEAR_FAULT,
		ST_WAIT_START,
		ST_DELAY,
		ST_ENABLE,
		ST_DONE,
		ST_DISABLE,
		ST_DOWN_DELAY
	} seq_state_e;
endpackage

// ---- sync_edge.sv ----
// three-stage synchroniser with agreeing-stage edge detection
// assumes an asynchronous level on din
`timescale 1ns/1ps
`default_nettype none
module sync_edge
	import seq_pkg::*;
#(
	parameter int WIDTH = 3
)
(
	input  wire logic             clk_sys,
	input  wire logic             rst_n,
	input  wire logic [WIDTH-1:0] din,
	output logic      [WIDTH-1:0] level,
	output logic      [WIDTH-1:0] rise,
	output logic      [WIDTH-1:0] fall
);
	logic [WIDTH-1:0] s1;
	logic [WIDTH-1:0] s2;
	logic [WIDTH-1:0] s3;
	genvar g;
	generate
		for (g = 0; g < WIDTH; g++)
		begin : g_bit
			always_ff @(posedge clk_sys)
			begin
				s1[g] <= din[g];
				s2[g] <= s1[g];
				s3[g] <= s2[g];
				if (!rst_n)
					level[g] <= 1'b0;
				else if (s2[g] == s3[g])
					level[g] <= s3[g];
			end
			assign rise[g] = (s2[g] == s3[g]) && s3[g] && !level[g];
			assign fall[g] = (s2[g] == s3[g]) && !s3[g] && level[g];
		end
	endgenerate
endmodule // sync_edge
`default_nettype wire

// ---- quad_rail_sequencer_fsm_properties.sv ----
// port assertions for the rail sequencer
// assumes binding onto quad_rail_sequencer_fsm
`timescale 1ns/1ps
`default_nettype none
module seq_props
	import seq_pkg::*;
(
	input wire logic       clk_sys,
	input wire logic       rst_n,
	input wire logic       reduced_variant,
	input wire logic [3:0] rail_good_in,
	input wire logic [3:0] rail_enable_out,
	input wire logic       sequence_complete,
	input wire logic       all_rails_good,
	input wire logic       fault_n_oe,
	input wire seq_state_e state_out
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	a_en_after_good: assert property ($rose(rail_enable_out[1]) |-> $past(rail_good_in[0], 3))
		else $error("early enable");
	a_down_order: assert property ($fell(rail_enable_out[3]) && state_out != ST_SET_FAULT
		|-> rail_enable_out[2:0] == 3'h7) else $error("down order");
	a_lockout_start: assert property ($rose(rst_n) |-> rail_enable_out == 4'h0
		&& !sequence_complete && !all_rails_good && state_out == ST_SET_FAULT) else $error("lockout");
	a_good_and: assert property ($past(rst_n) |-> all_rails_good == &$past(rail_good_in))
		else $error("good and");
	a_fault_clear: assert property (state_out == ST_SET_FAULT && $past(state_out) == ST_SET_FAULT
		|-> rail_enable_out == 4'h0 && !sequence_complete) else $error("fault outputs");
	a_fault_hold: assert property (state_out == ST_SET_FAULT && $past(state_out) != ST_SET_FAULT
		|-> state_out == ST_SET_FAULT [*4]) else $error("fault hold");
	a_done_high: assert property (state_out == ST_DONE && $past(state_out) == ST_DONE
		|-> sequence_complete && rail_enable_out == 4'hf) else $error("done");
	a_done_linger: assert property ($fell(rail_enable_out[0]) && !reduced_variant
		&& state_out != ST_SET_FAULT |-> sequence_complete [*3]) else $error("done linger");
	a_line_release: assert property (state_out == ST_WAIT_START
		&& $past(state_out) == ST_WAIT_START |-> !fault_n_oe) else $error("line held");
	a_no_line: assert property (reduced_variant && $past(reduced_variant) |-> !fault_n_oe)
		else $error("line used");
endmodule // seq_props
bind quad_rail_sequencer_fsm seq_props u_props (.clk_sys(clk_sys), .rst_n(rst_n),
	.reduced_variant(reduced_variant), .rail_good_in(rail_good_in), .rail_enable_out(rail_enable_out),
	.sequence_complete(sequence_complete), .all_rails_good(all_rails_good), .fault_n_oe(fault_n_oe),
	.state_out(state_out));
`default_nettype wire

// ---- rail_model.sv ----
// regulator model: good follows enable after a lag
// assumes enables from the sequencer; kill holds a rail bad
`timescale 1ns/1ps
`default_nettype none
module rail_model
(
	input  wire logic       clk_sys,
	input  wire logic       slow,
	input  wire logic [3:0] en,
	input  wire logic [3:0] kill,
	output logic      [3:0] good
);
	logic [3:0] d1, d2, d3;
	always_ff @(posedge clk_sys)
	begin
		d1 <= en;
		d2 <= d1 & en;
		d3 <= d2 & en;
	end
	assign good = (slow ? d3 : d1) & en & ~kill;
endmodule // rail_model
`default_nettype wire

// ---- quad_rail_sequencer_fsm_tb_top.sv ----
// self-checking bench for the rail sequencer
// assumes rail_model as regulators, fault line pulled up
`timescale 1ns/1ps
`default_nettype none
module quad_rail_sequencer_fsm_tb_top
	import seq_pkg::*;
;
	logic       clk_sys = 0, rst_n = 0, rv = 0, slow = 0, up = 1, down = 1, done, pg, f_oe, fo;
	logic [3:0] kill = 0, good, en, prev;
	count_t     sd [4];
	seq_state_e st;
	int         num_errors = 0, checked = 0;
	logic [7:0] expq [$];
	initial forever #20 clk_sys = ~clk_sys;
	quad_rail_sequencer_fsm DUT (.clk_sys(clk_sys), .rst_n(rst_n), .reduced_variant(rv), .rail_good_in(good),
		.request_in({up, down, f_oe ? fo : 1'b1}), .stage_delay(sd), .blanking_window(24'h000014),
		.fault_hold(24'h000008), .rail_enable_out(en), .sequence_complete(done), .all_rails_good(pg),
		.fault_n_out(fo), .fault_n_oe(f_oe), .state_out(st));
	rail_model REG (.clk_sys(clk_sys), .slow(slow), .en(en), .kill(kill), .good(good));
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp)
		begin
			num_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	task automatic wst(input seq_state_e s);
		for (int n = 0; st !== s && n < 3000; n++)
			cyc(1);
		chk(st, s);
	endtask
	task automatic up_seq(input int k);
		for (int i = 0; i <= k; i++)
			expq.push_back(8'((1 << (i + 1)) - 1));
	endtask
	task automatic stop_test();
		$display("checked %0d num_errors %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// enable change model
	always @(posedge clk_sys)
	begin
		if (rst_n && en !== prev)
			chk(en, expq.size() ? expq.pop_front() : 8'hff);
		prev = en;
	end
	initial
	begin
		int k;
		void'($urandom(11218));
		for (int i = 0; i < 4; i++)
			sd[i] = 24'(3 + $urandom % 4);
		for (int v = 0; v < 2; v++)
		begin
			rst_n = 0;
			rv = v[0];
			slow = v[0];
			up = 1;
			cyc(6);
			rst_n = 1;
			cyc(1);
			chk({done, en}, 0);
			wst(ST_CLEAR_FAULT);
			cyc(20);
			chk(st, ST_CLEAR_FAULT);
			up = 0;
			wst(ST_WAIT_START);
			cyc(1);
			chk(f_oe, 0);
			// reduced host waits after supply up
			if (rv)
				cyc(12500);
			up_seq(3);
			up = 1;
			wst(ST_DONE);
			cyc(2);
			chk({done, pg, en}, 8'h3f);
			expq = '{8'h7, 8'h3, 8'h1, 8'h0};
			if (v)
				up = 0;
			else
				down = 0;
			wst(ST_WAIT_START);
			cyc(2);
			chk({done, pg, 6'(expq.size())}, 0);
			down = 1;
			up = 0;
			cyc(8);
			k = $urandom % 4;
			kill[k] = 1;
			up_seq(k);
			expq.push_back(0);
			up = 1;
			wst(ST_SET_FAULT);
			cyc(2);
			chk({done, en}, 0);
			chk({f_oe, fo}, {!rv, 1'b0});
			kill = 0;
			up = 0;
			wst(ST_WAIT_START);
			// rail one lost after its good
			expq = '{8'h1, 8'h0};
			up = 1;
			wait (en[0] === 1'b1);
			cyc(5);
			kill[0] = 1;
			wst(ST_SET_FAULT);
			cyc(2);
			chk({done, en}, 0);
			kill = 0;
			up = 0;
			wst(ST_WAIT_START);
		end
		stop_test();
	end
	initial
	begin
		#2000000;
		num_errors++;
		stop_test();
	end
endmodule // quad_rail_sequencer_fsm_tb_top
`default_nettype wire
